// [src/exc_entry_pkg.sv]
// Constants, cause codes and types for the exception and interrupt entry unit.
// Assumes a single core clock and a decoder that flags instruction boundaries.
//
// How it works
// - Bad delay-slot instruction raises illegal-slot exception.
// - Illegal slot saves branch PC, cause 1A0.
// - Global base loads/stores are never privileged.
// - User break saves proper PC, cause 1E0.
// - NMI edge detected, cause 1C0, vector 600.
// - NMI ignores mask, top priority unless held.
// - Level interrupt when mask below level, unheld.
// - Level cause code is 200 plus level*20.
// - Accepting interrupt leaves level mask unchanged.
// - Module interrupt accepted likewise, vector 600.
// - Module levels come from four-bit priority fields.
// - Return restores PC and status from saved copies.
// - Hold delays interrupts except in sleep.
// - No user break trap while held.
// - Other exception while held goes to reset.
// - Re-executing exceptions save faulting or branch PC.
// - Completed exceptions save next, target or slot PC.
// - Reset clears base, sets flags, mask F.
// - Cause code fills low twelve bits.
`default_nettype none
package exc_entry_pkg;
	// ****************************************
	// Status word fields
	// ****************************************
	localparam int SR_MD_BIT = 30; // Privileged flag position.
	localparam int SR_RB_BIT = 29; // Register bank flag position.
	localparam int SR_BL_BIT = 28; // Exception hold bit position.
	localparam int SR_IM_LO = 4; // Low bit of the interrupt level mask.
	localparam int SR_IM_HI = 7; // High bit of the interrupt level mask.
	localparam logic [3:0] INTERRUPT_LEVEL_MASK_RESET = 4'hF; // Mask value after reset.
	localparam logic [31:0] SR_RESET = 32'h700000F0; // Flags set and mask F.
	// ****************************************
	// Vectors and cause codes
	// ****************************************
	localparam logic [31:0] RESET_PC = 32'hA0000000; // Fixed reset address.
	localparam logic [31:0] VBR_RESET = 32'h00000000; // Vector base after reset.
	localparam logic [31:0] OFS_GENERAL = 32'h00000100; // General exception offset.
	localparam logic [31:0] OFS_INTR = 32'h00000600; // Interrupt offset.
	localparam logic [11:0] CODE_POR = 12'h000; // Power-on reset cause.
	localparam logic [11:0] CODE_MANUAL = 12'h020; // Manual reset cause.
	localparam logic [11:0] CODE_ILL_SLOT = 12'h1A0; // Illegal slot cause.
	localparam logic [11:0] CODE_UBRK = 12'h1E0; // User break cause.
	localparam logic [11:0] CODE_NMI = 12'h1C0; // Non-maskable interrupt cause.
	localparam logic [11:0] CODE_IRL_BASE = 12'h200; // Level interrupt base code.
	localparam int IRL_STEP_SHIFT = 5; // Step of 20 hex between levels.
	localparam logic [3:0] UNDEF_OP_TOP = 4'hF; // Undefined opcodes start with F.
	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [2:0] {
		EV_NONE, EV_NMI, EV_IRL, EV_MOD, EV_ILL, EV_UBRK, EV_OTHER, EV_RTE
	} event_t;
endpackage : exc_entry_pkg
`default_nettype wire

// [src/exc_entry.sv]
// Exception and interrupt entry and return logic of the core.
// Assumes the pipeline presents one retiring instruction per boundary strobe.
`default_nettype none
module exc_entry (
	input wire logic clk_sys_in, // Core clock, 100 MHz.
	input wire logic rst_in, // Synchronous reset, active high.
	input wire logic manual_reset_in, // High selects manual over power-on reset cause.
	input wire logic boundary_in, // One-cycle: an instruction boundary.
	input wire logic [15:0] opcode_in, // Opcode being decoded.
	input wire logic in_delay_slot_in, // Opcode sits in a delay slot.
	input wire logic slot_pc_write_in, // Delay-slot opcode rewrites the PC.
	input wire logic priv_instr_in, // Opcode is a control or privileged instruction.
	input wire logic gbr_access_in, // Control load or store targets global base reg.
	input wire logic [31:0] cur_pc_in, // PC of the decoded instruction.
	input wire logic [31:0] next_pc_in, // PC of the following instruction.
	input wire logic [31:0] branch_pc_in, // PC of the preceding delayed branch.
	input wire logic [31:0] target_pc_in, // Branch target of a delayed conditional.
	input wire logic cond_taken_in, // Condition of the delayed branch is met.
	input wire logic [31:0] status_in, // Status word of the current instruction.
	input wire logic ubrk_in, // One-cycle: break condition met.
	input wire logic ubrk_post_in, // High for a post-execution break.
	input wire logic other_exc_in, // One-cycle: any other general exception.
	input wire logic [11:0] other_code_in, // Cause code of that exception.
	input wire logic other_reexec_in, // That exception is re-executing type.
	input wire logic nmi_pin_in, // Non-maskable interrupt pin.
	input wire logic [3:0] external_level_inputs_in, // Encoded external level.
	input wire logic mod_req_in, // Module interrupt request.
	input wire logic [3:0] mod_level_in, // Priority field of that module.
	input wire logic [11:0] mod_code_in, // Source-specific module cause.
	input wire logic sleep_in, // Core is in sleep or standby.
	input wire logic rte_in, // One-cycle: exception return executes.
	input wire logic sr_write_in, // One-cycle: software writes the status word.
	input wire logic [31:0] sr_wdata_in, // Value written to the status word.
	input wire logic vbr_write_in, // One-cycle: software writes the vector base.
	input wire logic [31:0] vbr_wdata_in, // Value written to the vector base.
	output logic redirect_out, // One-cycle: fetch jumps to redirect_pc_out.
	output logic [31:0] redirect_pc_out, // New fetch address.
	output logic [31:0] saved_pc_out, // Saved program counter.
	output logic [31:0] saved_status_out, // Saved status word.
	output logic [31:0] status_word_out, // Live status word.
	output logic [31:0] vector_base_out, // Vector base.
	output logic [11:0] exception_cause_code_out, // Exception cause.
	output logic [11:0] interrupt_cause_code_out, // Interrupt cause.
	output logic nmi_pending_out // Detected NMI edge waits for acceptance.
);
	// ****************************************
	// Event decode
	// ****************************************
	logic nmi_prev_ff; // Previous pin sample, used for edge detection.
	logic nmi_pend_ff; // Latched edge.
	logic hold; // Exception hold bit of the live status.
	logic [3:0] interrupt_level_mask; // Live interrupt level mask.
	logic user_mode; // Not privileged.
	logic ill_slot; // Illegal-slot condition.
	logic int_ok; // Interrupts may be taken now.
	exc_entry_pkg::event_t ev; // Winning event this cycle.

	assign hold = status_word_out[exc_entry_pkg::SR_BL_BIT];
	assign interrupt_level_mask = status_word_out[exc_entry_pkg::SR_IM_HI:exc_entry_pkg::SR_IM_LO];
	assign user_mode = !status_word_out[exc_entry_pkg::SR_MD_BIT];
	// Sleep overrides hold so a sleeping core can always be woken.
	assign int_ok = boundary_in && (!hold || sleep_in);

	// Illegal slot: undefined, PC-writing, or privileged-in-user in a slot.
	always_comb begin
		ill_slot = 1'b0;
		if (boundary_in && in_delay_slot_in) begin
			if (opcode_in[15:12] == exc_entry_pkg::UNDEF_OP_TOP) begin
				ill_slot = 1'b1;
			end else if (slot_pc_write_in) begin
				ill_slot = 1'b1;
			end else if (priv_instr_in && !gbr_access_in && user_mode) begin
				ill_slot = 1'b1;
			end
		end
	end

	// Priority: NMI, then level/module by level, then exceptions, then return.
	always_comb begin
		ev = exc_entry_pkg::EV_NONE;
		if (nmi_pend_ff && int_ok) begin
			ev = exc_entry_pkg::EV_NMI;
		end else if (int_ok && (external_level_inputs_in > interrupt_level_mask)
				&& (!mod_req_in || external_level_inputs_in >= mod_level_in)) begin
			ev = exc_entry_pkg::EV_IRL;
		end else if (int_ok && mod_req_in && (mod_level_in > interrupt_level_mask)) begin
			ev = exc_entry_pkg::EV_MOD;
		end else if (ill_slot) begin
			ev = exc_entry_pkg::EV_ILL;
		end else if (ubrk_in && !hold) begin
			ev = exc_entry_pkg::EV_UBRK;
		end else if (other_exc_in) begin
			ev = exc_entry_pkg::EV_OTHER;
		end else if (rte_in) begin
			ev = exc_entry_pkg::EV_RTE;
		end else begin
			ev = exc_entry_pkg::EV_NONE;
		end
	end

	// ****************************************
	// Non-maskable edge detector
	// ****************************************
	// The edge stays pending while held, so it is taken once hold clears.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			nmi_prev_ff <= 1'b0;
			nmi_pend_ff <= 1'b0;
		end else begin
			nmi_prev_ff <= nmi_pin_in;
			if (nmi_pin_in && !nmi_prev_ff) begin
				nmi_pend_ff <= 1'b1;
			end else if (ev == exc_entry_pkg::EV_NMI) begin
				nmi_pend_ff <= 1'b0;
			end
		end
	end

	// The flag mirrors the next pending state, so it drops in the same cycle as acceptance.
	// A plain copy of the latch would report a stale request for one cycle after entry.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			nmi_pending_out <= 1'b0;
		end else begin
			nmi_pending_out <= (nmi_pin_in && !nmi_prev_ff)
				|| (nmi_pend_ff && (ev != exc_entry_pkg::EV_NMI));
		end
	end

	// ****************************************
	// Saved PC selection
	// ****************************************
	// Completed-type entries save the next PC, or the target or slot PC.
	function automatic logic [31:0] completed_pc(input logic slot, input logic taken,
			input logic [31:0] nxt, input logic [31:0] tgt, input logic [31:0] cur);
		if (!slot) begin
			completed_pc = nxt;
		end else if (taken) begin
			completed_pc = tgt;
		end else begin
			completed_pc = cur;
		end
	endfunction : completed_pc

	logic [31:0] nxt_saved_pc; // PC value to save on entry.
	always_comb begin
		nxt_saved_pc = saved_pc_out;
		case (ev)
			exc_entry_pkg::EV_NMI, exc_entry_pkg::EV_IRL, exc_entry_pkg::EV_MOD: begin
				nxt_saved_pc = completed_pc(in_delay_slot_in, cond_taken_in,
					next_pc_in, target_pc_in, cur_pc_in);
			end
			exc_entry_pkg::EV_ILL: begin
				nxt_saved_pc = branch_pc_in;
			end
			exc_entry_pkg::EV_UBRK: begin
				nxt_saved_pc = ubrk_post_in ? next_pc_in : cur_pc_in;
			end
			exc_entry_pkg::EV_OTHER: begin
				if (!other_reexec_in) begin
					nxt_saved_pc = completed_pc(in_delay_slot_in, cond_taken_in,
						next_pc_in, target_pc_in, cur_pc_in);
				end else if (in_delay_slot_in && cond_taken_in) begin
					nxt_saved_pc = branch_pc_in;
				end else begin
					nxt_saved_pc = cur_pc_in;
				end
			end
			default: begin
				nxt_saved_pc = saved_pc_out;
			end
		endcase
	end

	// ****************************************
	// Entry and return state
	// ****************************************
	logic entry; // Any accepted entry to a handler.
	logic [31:0] entry_sr; // Status word with hold, privilege and bank set.
	logic [31:0] lvl_code; // Level interrupt cause code, wide for the shift.
	assign entry = (ev != exc_entry_pkg::EV_NONE) && (ev != exc_entry_pkg::EV_RTE);
	always_comb begin
		entry_sr = status_word_out;
		entry_sr[exc_entry_pkg::SR_BL_BIT] = 1'b1;
		entry_sr[exc_entry_pkg::SR_MD_BIT] = 1'b1;
		entry_sr[exc_entry_pkg::SR_RB_BIT] = 1'b1;
	end
	assign lvl_code = {20'h00000, exc_entry_pkg::CODE_IRL_BASE}
		+ ({28'h0000000, external_level_inputs_in} << exc_entry_pkg::IRL_STEP_SHIFT);

	// Status word: reset value, entry flags, return restore, software write.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			status_word_out <= exc_entry_pkg::SR_RESET;
		end else if (ev == exc_entry_pkg::EV_RTE) begin
			status_word_out <= saved_status_out;
		end else if (entry) begin
			status_word_out <= entry_sr;
		end else if (sr_write_in) begin
			status_word_out <= sr_wdata_in;
		end
	end

	// Vector base: cleared at reset, written only by software.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			vector_base_out <= exc_entry_pkg::VBR_RESET;
		end else if (vbr_write_in) begin
			vector_base_out <= vbr_wdata_in;
		end
	end

	// Saved copies are reset: PC to the vector base reset value, status to the reset status word.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			saved_pc_out <= exc_entry_pkg::VBR_RESET;
			saved_status_out <= exc_entry_pkg::SR_RESET;
		end else if (entry) begin
			saved_pc_out <= nxt_saved_pc;
			saved_status_out <= status_word_out;
		end
	end

	// Cause registers; hold-time exceptions leave them undefined, written here as on any entry.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			exception_cause_code_out <= manual_reset_in ? exc_entry_pkg::CODE_MANUAL
				: exc_entry_pkg::CODE_POR;
			interrupt_cause_code_out <= exc_entry_pkg::CODE_POR;
		end else begin
			case (ev)
				exc_entry_pkg::EV_NMI: begin
					interrupt_cause_code_out <= exc_entry_pkg::CODE_NMI;
				end
				exc_entry_pkg::EV_IRL: begin
					interrupt_cause_code_out <= lvl_code[11:0];
				end
				exc_entry_pkg::EV_MOD: begin
					interrupt_cause_code_out <= mod_code_in;
				end
				exc_entry_pkg::EV_ILL: begin
					exception_cause_code_out <= exc_entry_pkg::CODE_ILL_SLOT;
				end
				exc_entry_pkg::EV_UBRK: begin
					exception_cause_code_out <= exc_entry_pkg::CODE_UBRK;
				end
				exc_entry_pkg::EV_OTHER: begin
					exception_cause_code_out <= other_code_in;
				end
				default: begin
					exception_cause_code_out <= exception_cause_code_out;
				end
			endcase
		end
	end

	// ****************************************
	// Fetch redirect
	// ****************************************
	// Redirect is registered with the state so nothing retires in between.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			redirect_out <= 1'b1;
			redirect_pc_out <= exc_entry_pkg::RESET_PC;
		end else begin
			redirect_out <= (ev != exc_entry_pkg::EV_NONE);
			case (ev)
				exc_entry_pkg::EV_NMI, exc_entry_pkg::EV_IRL, exc_entry_pkg::EV_MOD: begin
					redirect_pc_out <= vector_base_out + exc_entry_pkg::OFS_INTR;
				end
				exc_entry_pkg::EV_ILL, exc_entry_pkg::EV_UBRK, exc_entry_pkg::EV_OTHER: begin
					if (hold) begin
						redirect_pc_out <= exc_entry_pkg::RESET_PC;
					end else begin
						redirect_pc_out <= vector_base_out
							+ exc_entry_pkg::OFS_GENERAL;
					end
				end
				exc_entry_pkg::EV_RTE: begin
					redirect_pc_out <= saved_pc_out;
				end
				default: begin
					redirect_pc_out <= redirect_pc_out;
				end
			endcase
		end
	end
endmodule : exc_entry
`default_nettype wire

// [dv/intc_model.sv]
// Behavioural model of the interrupt controller feeding module requests.
// Assumes the bench picks the raising source and programs its priority fields.
`default_nettype none
module intc_model #(
	parameter logic [11:0] CODE_BASE = 12'h400 // Cause of source 0, an arbitrary value.
) (
	input wire logic [15:0] prio_in, // Four packed four-bit priority fields.
	input wire logic [1:0] src_in, // Source raising the request.
	input wire logic req_in, // Request from that source.
	output logic mod_req_out, // Request towards the core.
	output logic [3:0] mod_level_out, // Level of the raising source.
	output logic [11:0] mod_code_out // Source-specific cause code.
);
	// ****
	// Source selection
	// ****
	// Combinational, so the level follows the fields with no delay.
	assign mod_req_out = req_in;
	assign mod_level_out = prio_in[{src_in, 2'b00} +: 4];
	assign mod_code_out = CODE_BASE + {5'h00, src_in, 5'h00};
endmodule : intc_model
`default_nettype wire

// [dv/exc_entry_monitor.sv]
// Checker of entry, return and reset behaviour at the unit's ports.
// Assumes it is bound to exc_entry and sees only its ports.
`default_nettype none
module exc_entry_monitor (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic boundary_in,
	input wire logic [15:0] opcode_in,
	input wire logic in_delay_slot_in,
	input wire logic slot_pc_write_in,
	input wire logic priv_instr_in,
	input wire logic gbr_access_in,
	input wire logic [31:0] cur_pc_in,
	input wire logic [31:0] next_pc_in,
	input wire logic [31:0] branch_pc_in,
	input wire logic [31:0] target_pc_in,
	input wire logic cond_taken_in,
	input wire logic ubrk_in,
	input wire logic ubrk_post_in,
	input wire logic other_exc_in,
	input wire logic [3:0] external_level_inputs_in,
	input wire logic mod_req_in,
	input wire logic [3:0] mod_level_in,
	input wire logic [11:0] mod_code_in,
	input wire logic sleep_in,
	input wire logic rte_in,
	input wire logic redirect_out,
	input wire logic [31:0] redirect_pc_out,
	input wire logic [31:0] saved_pc_out,
	input wire logic [31:0] saved_status_out,
	input wire logic [31:0] status_word_out,
	input wire logic [31:0] vector_base_out,
	input wire logic [11:0] exception_cause_code_out,
	input wire logic [11:0] interrupt_cause_code_out,
	input wire logic nmi_pending_out
);
	// ****
	// Decode helpers
	// ****
	// Sleep lets interrupts through the hold bit, so it enters int_ok.
	wire logic hold = status_word_out[28];
	wire logic [3:0] mask = status_word_out[7:4];
	wire logic int_ok = boundary_in && (!hold || sleep_in);
	wire logic lvl_hit = external_level_inputs_in > mask;
	wire logic mod_hit = mod_req_in && mod_level_in > mask;
	wire logic int_any = int_ok && (nmi_pending_out || lvl_hit || mod_hit);
	wire logic bad_slot = boundary_in && in_delay_slot_in && (opcode_in[15:12] == 4'hF ||
		slot_pc_write_in || (priv_instr_in && !gbr_access_in && !status_word_out[30]));
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	// ****
	// Properties
	// ****
	property p_nmi; int_ok && nmi_pending_out |=> redirect_out && status_word_out[30:28] == 3'h7
		&& interrupt_cause_code_out == 12'h1C0 && redirect_pc_out == $past(vector_base_out) + 32'h600;
	endproperty
	a_nmi: assert property (p_nmi) else $error("nmi entry wrong");
	property p_nmi_held; nmi_pending_out && boundary_in && hold && !sleep_in |=>
		nmi_pending_out && $stable(interrupt_cause_code_out); endproperty
	a_nmi_held: assert property (p_nmi_held) else $error("nmi taken while held");
	property p_level; int_ok && !nmi_pending_out && lvl_hit && !(mod_hit &&
		mod_level_in > external_level_inputs_in) |=> interrupt_cause_code_out ==
		12'h200 + {3'h0, $past(external_level_inputs_in), 5'h00}; endproperty
	a_level: assert property (p_level) else $error("level cause wrong");
	property p_mask_kept; int_ok && !nmi_pending_out && (lvl_hit || mod_hit) |=>
		status_word_out[7:4] == $past(mask) && saved_pc_out == (!$past(in_delay_slot_in)
		? $past(next_pc_in) : $past(cond_taken_in) ? $past(target_pc_in) : $past(cur_pc_in));
	endproperty
	a_mask_kept: assert property (p_mask_kept) else $error("mask or pc wrong");
	property p_module; int_ok && !nmi_pending_out && !lvl_hit && mod_hit |=> redirect_out &&
		interrupt_cause_code_out == $past(mod_code_in); endproperty
	a_module: assert property (p_module) else $error("module entry wrong");
	property p_ill; bad_slot && !int_any && !hold |=> exception_cause_code_out == 12'h1A0 &&
		saved_pc_out == $past(branch_pc_in) && saved_status_out == $past(status_word_out);
	endproperty
	a_ill: assert property (p_ill) else $error("illegal slot entry wrong");
	property p_break; ubrk_in && !hold && !int_any && !bad_slot |=> exception_cause_code_out ==
		12'h1E0 && saved_pc_out == ($past(ubrk_post_in) ? $past(next_pc_in) : $past(cur_pc_in));
	endproperty
	a_break: assert property (p_break) else $error("break entry wrong");
	property p_no_break; ubrk_in && hold && !boundary_in && !other_exc_in && !rte_in |=>
		!redirect_out; endproperty
	a_no_break: assert property (p_no_break) else $error("break taken while held");
	property p_held_exc; other_exc_in && hold && !int_any |=> redirect_out &&
		redirect_pc_out == 32'hA0000000; endproperty
	a_held_exc: assert property (p_held_exc) else $error("held exception not to reset");
	property p_rte; rte_in && !int_any && !bad_slot && !ubrk_in && !other_exc_in |=>
		redirect_pc_out == $past(saved_pc_out) && status_word_out == $past(saved_status_out);
	endproperty
	a_rte: assert property (p_rte) else $error("return wrong");
	property p_reset; disable iff (1'b0) rst_in |=> status_word_out[30:28] == 3'h7 &&
		mask == 4'hF && vector_base_out == 32'h0 && redirect_pc_out == 32'hA0000000; endproperty
	a_reset: assert property (p_reset) else $error("reset state wrong");
endmodule : exc_entry_monitor
bind exc_entry exc_entry_monitor exc_entry_monitor_inst (.*);
`default_nettype wire

// [dv/tb.sv]
// Self-checking bench of the exception entry unit with a module-interrupt model.
// Assumes inputs change at the falling edge and outputs are registered.
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
	$display("[ERR] %0t got %h expected %h", $time, (a), (b)); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_in = 1'b0, rst_in = 1'b1, manual_reset_in = 1'b0, boundary_in = 1'b0;
	logic in_delay_slot_in = 1'b0, slot_pc_write_in = 1'b0, priv_instr_in = 1'b0;
	logic gbr_access_in = 1'b0, cond_taken_in = 1'b0, ubrk_in = 1'b0, ubrk_post_in = 1'b0;
	logic other_exc_in = 1'b0, other_reexec_in = 1'b0, nmi_pin_in = 1'b0, sleep_in = 1'b0;
	logic rte_in = 1'b0, sr_write_in = 1'b0, vbr_write_in = 1'b0, mod_req_in, req = 1'b0;
	logic [15:0] opcode_in = 16'h0000, prio = 16'h0000;
	logic [31:0] cur_pc_in = 32'h100, next_pc_in = 32'h102, branch_pc_in = 32'hFE;
	logic [31:0] target_pc_in = 32'h200, status_in = 32'h0, sr_wdata_in = 32'h0;
	logic [31:0] vbr_wdata_in = 32'h8C000000;
	logic [3:0] external_level_inputs_in = 4'h0, mod_level_in;
	logic [11:0] other_code_in = 12'h0E0, mod_code_in;
	logic [1:0] src = 2'h1;
	logic redirect_out, nmi_pending_out;
	logic [31:0] redirect_pc_out, saved_pc_out, saved_status_out, status_word_out, vector_base_out;
	logic [11:0] exception_cause_code_out, interrupt_cause_code_out;
	int mismatches = 0, cmp_count = 0, cycles = 0;
	exc_entry exc_entry_inst (.*);
	intc_model intc_model_inst (.prio_in(prio), .src_in(src), .req_in(req),
		.mod_req_out(mod_req_in), .mod_level_out(mod_level_in), .mod_code_out(mod_code_in));
	// ****
	// Clock, watchdog and access tasks
	// ****
	always #5 clk_sys_in = ~clk_sys_in;
	// A hang is cut off well beyond the roughly 130 cycles the sequence needs.
	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			$display("[ERR] %0t timeout", $time);
			complete_run;
		end
	end
	// One taking edge, pulses dropped, then an idle cycle so no signal is set twice at once.
	task go;
		@(negedge clk_sys_in);
		{boundary_in, ubrk_in, other_exc_in, rte_in, sr_write_in, vbr_write_in, req} = 7'h00;
		@(negedge clk_sys_in);
	endtask : go
	task sr(input logic [31:0] v);
		sr_wdata_in = v;
		sr_write_in = 1'b1;
		go;
	endtask : sr
	task complete_run;
		$display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : complete_run
	// ****
	// Main sequence
	// ****
	initial begin
		repeat (2) @(negedge clk_sys_in);
		`CHK(status_word_out[30:28], 3'h7)
		`CHK({status_word_out[7:4], vector_base_out, redirect_pc_out}, {4'hF, 64'hA0000000})
		rst_in = 1'b0;
		vbr_write_in = 1'b1;
		go;
		for (int lv = 1; lv < 16; lv++) begin
			sr(32'h40000000);
			external_level_inputs_in = 4'(lv);
			boundary_in = 1'b1;
			go;
			external_level_inputs_in = 4'h0;
			`CHK(interrupt_cause_code_out, 12'h200 + 12'(lv * 32))
			`CHK({redirect_pc_out, saved_pc_out}, {32'h8C000600, next_pc_in})
			`CHK({status_word_out[30:28], status_word_out[7:4]}, 7'h70)
		end
		sr(32'h40000050);
		external_level_inputs_in = 4'h5;
		boundary_in = 1'b1;
		go;
		`CHK(interrupt_cause_code_out, 12'h3E0)
		external_level_inputs_in = 4'h6;
		boundary_in = 1'b1;
		go;
		{nmi_pin_in, boundary_in} = 2'b11;
		go;
		`CHK({nmi_pending_out, interrupt_cause_code_out}, 13'h12C0)
		// The boundary stays up so the pending NMI meets the hold bit once more.
		{rte_in, boundary_in} = 2'b11;
		go;
		`CHK({status_word_out, redirect_pc_out}, {32'h40000050, next_pc_in})
		external_level_inputs_in = 4'hF;
		boundary_in = 1'b1;
		go;
		`CHK({interrupt_cause_code_out, redirect_pc_out}, {12'h1C0, 32'h8C000600})
		{nmi_pin_in, sleep_in, boundary_in} = 3'b011;
		external_level_inputs_in = 4'h7;
		go;
		`CHK(interrupt_cause_code_out, 12'h2E0)
		{sleep_in, external_level_inputs_in} = 5'h00;
		for (int k = 0; k < 2; k++) begin
			sr(32'h40000020);
			prio = k ? 16'h0010 : 16'h0070;
			{req, boundary_in} = 2'b11;
			go;
			`CHK(interrupt_cause_code_out, 12'h420)
		end
		for (int k = 0; k < 3; k++) begin
			sr(32'h0);
			opcode_in = k == 0 ? 16'hF123 : 16'h0009;
			{in_delay_slot_in, slot_pc_write_in, priv_instr_in, boundary_in} = {1'b1, k == 1, k == 2, 1'b1};
			go;
			`CHK({exception_cause_code_out, saved_pc_out}, {12'h1A0, branch_pc_in})
			`CHK({redirect_pc_out, saved_status_out}, {32'h8C000100, 32'h0})
		end
		{in_delay_slot_in, slot_pc_write_in, priv_instr_in} = 3'h0;
		for (int k = 0; k < 2; k++) begin
			sr(32'h40000000);
			{ubrk_in, ubrk_post_in} = {1'b1, k == 1};
			go;
			`CHK({exception_cause_code_out, saved_pc_out}, {12'h1E0, k ? next_pc_in : cur_pc_in})
		end
		sr(32'h0);
		{in_delay_slot_in, priv_instr_in, gbr_access_in, boundary_in} = 4'hF;
		go;
		`CHK({exception_cause_code_out, status_word_out[28]}, 13'h3C0)
		{in_delay_slot_in, priv_instr_in, gbr_access_in} = 3'h0;
		sr(32'h50000000);
		cur_pc_in = 32'h300;
		{ubrk_in, ubrk_post_in} = 2'b10;
		go;
		`CHK(saved_pc_out, 32'h102)
		other_exc_in = 1'b1;
		go;
		`CHK(redirect_pc_out, 32'hA0000000)
		for (int k = 0; k < 2; k++) begin
			sr(32'h40000000);
			{other_exc_in, other_reexec_in, in_delay_slot_in, cond_taken_in} = {3'h7, k == 1};
			go;
			`CHK(saved_pc_out, k ? branch_pc_in : cur_pc_in)
			`CHK({exception_cause_code_out, redirect_pc_out}, {12'h0E0, 32'h8C000100})
		end
		// A manual reset in mid-run restores the reset state and selects its own cause.
		{rst_in, manual_reset_in} = 2'b11;
		go;
		`CHK(exception_cause_code_out, 12'h020)
		`CHK({status_word_out, vector_base_out}, {32'h700000F0, 32'h00000000})
		rst_in = 1'b0;
		go;
		complete_run;
	end
endmodule : tb
`default_nettype wire
